// file: verilog/rie_defines.svh
`ifndef RIE_DEFINES_SVH
`define RIE_DEFINES_SVH

// Register bus widths
`define RIE_ADDR_W        8
`define RIE_DATA_W        16
`define RIE_NODES         16

// Register word offsets
`define RIE_OFS_FLAGS     8'h04
`define RIE_OFS_CAPTURE   8'h05
`define RIE_OFS_MISS_OUT  8'h06
`define RIE_OFS_MISS_IN   8'h07
`define RIE_OFS_UNREG_OUT 8'h08
`define RIE_OFS_UNREG_IN  8'h09
`define RIE_OFS_CTRL      8'h0A
`define RIE_OFS_IRQ_STAT  8'h0B
`define RIE_OFS_IRQ_MASK  8'h0C

// Flag word bit positions
`define RIE_BIT_MISSING   8
`define RIE_BIT_UNREG     9
`define RIE_BIT_STOPPED   10
`define RIE_BIT_ERROR     15

// Capture word fields
`define RIE_CAP_NODE_LSB  0
`define RIE_CAP_NODE_MSB  7
`define RIE_CAP_TYPE      15

// Control word bits
`define RIE_CTRL_STOP_MODE 0
`define RIE_CTRL_RESTART   1

// Interrupt event bits
`define RIE_IRQ_W         3
`define RIE_IRQ_MISSING   0
`define RIE_IRQ_UNREG     1
`define RIE_IRQ_STOPPED   2

// Reset values
`define RIE_WORD_RST      16'h0000
`define RIE_IRQ_RST       3'h0

`endif

// file: verilog/rie_pkg.sv
`default_nettype none
package rie_pkg;
  // Slave kind as seen on the network
  typedef enum logic {
    RIE_SLAVE_OUTPUT,
    RIE_SLAVE_INPUT
  } rie_slave_e;

  typedef logic [15:0] rie_word_t;
  typedef logic [3:0]  rie_node_t;
endpackage
`default_nettype wire

// file: verilog/rie_node_bits.sv
`timescale 1ns/1ps
`default_nettype none
`include "rie_defines.svh"
module rie_node_bits
  import rie_pkg::*;
(
  // Clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  // Restart clears every bit
  input  wire logic      clear_i,
  // One-cycle set request for one node
  input  wire logic      set_i,
  input  wire rie_node_t node_i,
  // Sticky per-node word
  output rie_word_t      bits_o
);
  // Sticky bit per node; a restart is a full reinitialisation so it wins
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      bits_o <= `RIE_WORD_RST;
    end else if (set_i) begin
      bits_o[node_i] <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: verilog/rie_irq.sv
`timescale 1ns/1ps
`default_nettype none
`include "rie_defines.svh"
module rie_irq
  import rie_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // Hardware events, one-cycle pulses
  input  wire logic [`RIE_IRQ_W-1:0] event_i,
  // Software access
  input  wire logic                  clr_we_i,
  input  wire logic                  mask_we_i,
  input  wire logic [`RIE_IRQ_W-1:0] wdata_i,
  // State
  output logic      [`RIE_IRQ_W-1:0] status_o,
  output logic      [`RIE_IRQ_W-1:0] mask_o,
  output logic                       irq_o
);
  // Sticky status, write one to clear; an event in the clear cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status_o <= `RIE_IRQ_RST;
    end else begin
      status_o <= (status_o & ~(clr_we_i ? wdata_i : `RIE_IRQ_RST)) | event_i;
    end
  end

  // Mask, one enables the matching status bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_o <= `RIE_IRQ_RST;
    end else if (mask_we_i) begin
      mask_o <= wdata_i;
    end
  end

  // Level output from a flop, one cycle behind status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status_o & mask_o);
    end
  end
endmodule
`default_nettype wire

// file: verilog/rie_top.sv
// Summary of operation
// - Stop-on-error comm error sets stopped flag
// - Stopped flag sticky until power or restart
// - Error flag set when bits 8-10 set
// - Error flag clears itself when all clear
// - Stop latches node number into capture low byte
// - Node number held until power or restart
// - Stop latches slave type into capture bit15
// - Slave type held until power or restart
// - Unregistered slaves marked per node, words 8/9
// - Missing flag follows missing slaves, self-clearing
// - Unregistered flag sticky even after slave leaves
`timescale 1ns/1ps
`default_nettype none
`include "rie_defines.svh"
module rie_top
  import rie_pkg::*;
(
  // Clock and reset (reset stands for a power cycle)
  input  wire logic                   clk_i,
  input  wire logic                   rst_i,
  // Register port
  input  wire logic [`RIE_ADDR_W-1:0] addr_i,
  input  wire logic [`RIE_DATA_W-1:0] wdata_i,
  input  wire logic                   wr_i,
  input  wire logic                   rd_i,
  output logic      [`RIE_DATA_W-1:0] rdata_o,
  // Unit restart request from the host unit
  input  wire logic                   restart_i,
  // Communications error report from the network engine
  input  wire logic                   comm_err_i,
  input  wire rie_node_t              comm_err_node_i,
  input  wire rie_slave_e             comm_err_type_i,
  // Registered slaves not yet joined, per node, levels
  input  wire rie_word_t              miss_out_i,
  input  wire rie_word_t              miss_in_i,
  // Unregistered slave joined, one-cycle pulse
  input  wire logic                   unreg_join_i,
  input  wire rie_node_t              unreg_node_i,
  input  wire rie_slave_e             unreg_type_i,
  // Status toward the network engine and the host
  output logic                        io_halt_o,
  output logic                        error_o,
  output logic                        irq_o
);

  // Register write strobes
  logic wr_ctrl;
  logic wr_irq_stat;
  logic wr_irq_mask;

  // Control state
  logic stop_mode_reg;
  logic restart_reg;
  logic restart_any;

  // Flag word state
  logic missing_reg;
  logic unreg_reg;
  logic stopped_reg;
  logic stopped_next;
  logic error_reg;
  logic error_next;

  // Capture word state
  rie_node_t  cap_node_reg;
  rie_slave_e cap_type_reg;
  logic       cap_take;

  // Per-node words
  rie_word_t miss_out_reg;
  rie_word_t miss_in_reg;
  rie_word_t unreg_out;
  rie_word_t unreg_in;
  logic      unreg_set_out;
  logic      unreg_set_in;

  // Interrupt wiring
  logic [`RIE_IRQ_W-1:0] irq_event;
  logic [`RIE_IRQ_W-1:0] irq_status;
  logic [`RIE_IRQ_W-1:0] irq_mask;
  logic                  missing_rise;
  logic                  unreg_rise;
  logic                  stopped_rise;

  // Assembled read words
  rie_word_t flags_word;
  rie_word_t capture_word;
  rie_word_t ctrl_word;
  rie_word_t rd_next;

  // Write decode; reads have no side effects in this block
  // Writes to read-only or unmapped offsets are dropped here,
  // so a stray store can never disturb the sticky status
  always_comb begin
    wr_ctrl     = wr_i && (addr_i == `RIE_OFS_CTRL);
    wr_irq_stat = wr_i && (addr_i == `RIE_OFS_IRQ_STAT);
    wr_irq_mask = wr_i && (addr_i == `RIE_OFS_IRQ_MASK);
  end

  // Stop-on-error mode select, kept across restarts like a setting
  // A power cycle returns the unit to run-through mode; a restart
  // keeps the selection so the host need not write it again
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stop_mode_reg <= 1'b0;
    end else if (wr_ctrl) begin
      stop_mode_reg <= wdata_i[`RIE_CTRL_STOP_MODE];
    end
  end

  // Software restart bit pulses for one cycle, then reads back zero
  // One-cycle delay keeps the clear out of the write cycle itself,
  // which lets a same-cycle mode write land first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      restart_reg <= 1'b0;
    end else begin
      restart_reg <= wr_ctrl && wdata_i[`RIE_CTRL_RESTART];
    end
  end

  // Either restart source reinitialises the sticky flags, capture and per-node words; irq status and mask are kept
  assign restart_any = restart_i || restart_reg;

  // Missing slave words mirror the participation monitor each cycle
  // Registered copy only; the flag below reads the live inputs so it
  // is not delayed a second cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_any) begin
      miss_out_reg <= `RIE_WORD_RST;
      miss_in_reg  <= `RIE_WORD_RST;
    end else begin
      miss_out_reg <= miss_out_i;
      miss_in_reg  <= miss_in_i;
    end
  end

  // Missing flag drops as soon as the last missing slave joins
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_any) begin
      missing_reg <= 1'b0;
    end else begin
      missing_reg <= |{miss_out_i, miss_in_i};
    end
  end

  // Route an unregistered join to the word of its slave kind
  assign unreg_set_out = unreg_join_i && (unreg_type_i == RIE_SLAVE_OUTPUT);
  assign unreg_set_in  = unreg_join_i && (unreg_type_i == RIE_SLAVE_INPUT);

  // Output slaves that joined unregistered
  rie_node_bits u_unreg_out (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (restart_any),
    .set_i   (unreg_set_out),
    .node_i  (unreg_node_i),
    .bits_o  (unreg_out)
  );

  // Input slaves that joined unregistered
  rie_node_bits u_unreg_in (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (restart_any),
    .set_i   (unreg_set_in),
    .node_i  (unreg_node_i),
    .bits_o  (unreg_in)
  );

  // Unregistered flag is sticky; the slave leaving does not clear it
  // Trade-off: a slave that joins and leaves in one scan still
  // leaves a trace here, which is what the host wants to see
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_any) begin
      unreg_reg <= 1'b0;
    end else if (unreg_join_i) begin
      unreg_reg <= 1'b1;
    end
  end

  // A comm error only halts exchange when stop-on-error is selected
  // With stop mode off the error is left to the network engine's
  // own retry and is not recorded here
  always_comb begin
    stopped_next = stopped_reg;
    if (comm_err_i && stop_mode_reg) begin
      stopped_next = 1'b1;
    end
  end

  // Stopped flag holds until power cycle or restart
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_any) begin
      stopped_reg <= 1'b0;
    end else begin
      stopped_reg <= stopped_next;
    end
  end

  // Capture only while not already stopped, so data match the flag
  // A second fault while halted would otherwise overwrite the
  // culprit of the first, which is the one the host must fix
  assign cap_take = comm_err_i && stop_mode_reg && !stopped_reg;

  // Node number of the slave that halted the network
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_any) begin
      cap_node_reg <= '0;
    end else if (cap_take) begin
      cap_node_reg <= comm_err_node_i;
    end
  end

  // Kind of the slave that halted the network
  always_ff @(posedge clk_i) begin
    if (rst_i || restart_any) begin
      cap_type_reg <= RIE_SLAVE_OUTPUT;
    end else if (cap_take) begin
      cap_type_reg <= comm_err_type_i;
    end
  end

  // Summary flag follows the three cause flags with no latching
  always_comb begin
    error_next = missing_reg | unreg_reg | stopped_reg;
  end

  // Registered every cycle, so it lags the cause bits by one cycle; the flag word reads error_next instead
  // Not cleared by restart: it follows the cause bits, which are
  // already cleared by it, one cycle later
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_reg <= 1'b0;
    end else begin
      error_reg <= error_next;
    end
  end

  // Rising edges of the cause flags feed the interrupt status
  assign missing_rise = !missing_reg && |{miss_out_i, miss_in_i};
  assign unreg_rise   = !unreg_reg && unreg_join_i;
  assign stopped_rise = !stopped_reg && stopped_next;

  // Pack events in status bit order
  // Events in the restart cycle are dropped, since the cause flags
  // themselves are being cleared in that same cycle
  always_comb begin
    irq_event                   = `RIE_IRQ_RST;
    irq_event[`RIE_IRQ_MISSING] = missing_rise && !restart_any;
    irq_event[`RIE_IRQ_UNREG]   = unreg_rise && !restart_any;
    irq_event[`RIE_IRQ_STOPPED] = stopped_rise && !restart_any;
  end

  // Sticky status with mask onto one level output
  rie_irq u_irq (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .event_i   (irq_event),
    .clr_we_i  (wr_irq_stat),
    .mask_we_i (wr_irq_mask),
    .wdata_i   (wdata_i[`RIE_IRQ_W-1:0]),
    .status_o  (irq_status),
    .mask_o    (irq_mask),
    .irq_o     (irq_o)
  );

  // Flag word; summary uses the live cause bits so the word is consistent
  always_comb begin
    flags_word                   = `RIE_WORD_RST;
    flags_word[`RIE_BIT_MISSING] = missing_reg;
    flags_word[`RIE_BIT_UNREG]   = unreg_reg;
    flags_word[`RIE_BIT_STOPPED] = stopped_reg;
    flags_word[`RIE_BIT_ERROR]   = error_next;
  end

  // Capture word; node sits zero-extended in the low byte
  always_comb begin
    capture_word                                       = `RIE_WORD_RST;
    capture_word[`RIE_CAP_NODE_MSB:`RIE_CAP_NODE_LSB] = {4'h0, cap_node_reg};
    capture_word[`RIE_CAP_TYPE]                        = (cap_type_reg == RIE_SLAVE_INPUT);
  end

  // Control word read-back; restart always reads zero
  always_comb begin
    ctrl_word                      = `RIE_WORD_RST;
    ctrl_word[`RIE_CTRL_STOP_MODE] = stop_mode_reg;
  end

  // Read mux; unmapped offsets answer zero
  always_comb begin
    rd_next = `RIE_WORD_RST;
    unique case (addr_i)
      `RIE_OFS_FLAGS:     rd_next = flags_word;
      `RIE_OFS_CAPTURE:   rd_next = capture_word;
      `RIE_OFS_MISS_OUT:  rd_next = miss_out_reg;
      `RIE_OFS_MISS_IN:   rd_next = miss_in_reg;
      `RIE_OFS_UNREG_OUT: rd_next = unreg_out;
      `RIE_OFS_UNREG_IN:  rd_next = unreg_in;
      `RIE_OFS_CTRL:      rd_next = ctrl_word;
      `RIE_OFS_IRQ_STAT:  rd_next = {13'h0000, irq_status};
      `RIE_OFS_IRQ_MASK:  rd_next = {13'h0000, irq_mask};
      default:            rd_next = `RIE_WORD_RST;
    endcase
  end

  // Read data valid only in the cycle after the strobe
  // Zero between reads keeps a bus OR of several slaves harmless,
  // at the cost of one extra flop load per cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_o <= `RIE_WORD_RST;
    end else if (rd_i) begin
      rdata_o <= rd_next;
    end else begin
      rdata_o <= `RIE_WORD_RST;
    end
  end

  // Halt line toward the network engine mirrors the sticky stop
  // The engine must stop exchange while this is high; it drops only
  // at the edge at which a restart clears the stopped flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_halt_o <= 1'b0;
    end else begin
      io_halt_o <= stopped_next && !restart_any;
    end
  end

  // Summary flag pin, two cycles behind the flag word view
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      error_o <= 1'b0;
    end else begin
      error_o <= error_reg;
    end
  end

endmodule
`default_nettype wire

// file: bench/rie_net_model.sv
`timescale 1ns/1ps
`default_nettype none
module rie_net_model
  import rie_pkg::*;
(
  // Clock
  input  wire logic clk_i,
  // Error and join reports
  output logic       err_o,
  output rie_node_t  err_node_o,
  output rie_slave_e err_type_o,
  output logic       join_o,
  output rie_node_t  join_node_o,
  output rie_slave_e join_type_o,
  // Missing-slave levels
  output rie_word_t  miss_out_o,
  output rie_word_t  miss_in_o
);
  initial begin
    {err_o, err_node_o, join_o, join_node_o} = '0;
    {miss_out_o, miss_in_o} = '0;
    err_type_o = RIE_SLAVE_OUTPUT;
    join_type_o = RIE_SLAVE_OUTPUT;
  end
  // Halting error; node lines do not keep the old value afterwards
  task fail(input rie_node_t n, input rie_slave_e t);
    @(posedge clk_i);
    err_o <= 1'b1;
    err_node_o <= n;
    err_type_o <= t;
    @(posedge clk_i);
    err_o <= 1'b0;
    err_node_o <= ~n;
  endtask
  // Unregistered slave joins for one cycle
  task join_unreg(input rie_node_t n, input rie_slave_e t);
    @(posedge clk_i);
    join_o <= 1'b1;
    join_node_o <= n;
    join_type_o <= t;
    @(posedge clk_i);
    join_o <= 1'b0;
    join_node_o <= ~n;
  endtask
  // Registered slaves absent, per node
  task miss(input rie_word_t o, input rie_word_t i);
    @(posedge clk_i);
    miss_out_o <= o;
    miss_in_o <= i;
  endtask
endmodule
`default_nettype wire

// file: bench/rie_top_properties.sv
`timescale 1ns/1ps
`default_nettype none
`include "rie_defines.svh"
module rie_top_properties
  import rie_pkg::*;
(
  input wire logic                   clk_i,
  input wire logic                   rst_i,
  input wire logic [`RIE_ADDR_W-1:0] addr_i,
  input wire logic [`RIE_DATA_W-1:0] wdata_i,
  input wire logic                   wr_i,
  input wire logic                   rd_i,
  input wire logic [`RIE_DATA_W-1:0] rdata_o,
  input wire logic                   restart_i,
  input wire logic                   comm_err_i,
  input wire rie_node_t              comm_err_node_i,
  input wire rie_slave_e             comm_err_type_i,
  input wire logic                   io_halt_o,
  input wire logic                   error_o,
  input wire logic                   irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic      mode_q;
  rie_word_t cap_q;
  logic      rs;
  logic      restart_q;
  // Control restart takes effect one cycle after its write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_i && addr_i == `RIE_OFS_CTRL && wdata_i[1];
    end
  end
  // Restart by pin or by the delayed control pulse
  assign rs = restart_i | restart_q;
  // Stop mode shadow; restart leaves it alone
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= 1'b0;
    end else if (wr_i && addr_i == `RIE_OFS_CTRL) begin
      mode_q <= wdata_i[0];
    end
  end
  // Expected capture word, first stop only
  always_ff @(posedge clk_i) begin
    if (rst_i || rs) begin
      cap_q <= 16'h0000;
    end else if (comm_err_i && mode_q && !io_halt_o) begin
      cap_q <= {comm_err_type_i, 11'h000, comm_err_node_i};
    end
  end
  chk_halt_sets: assert property (comm_err_i && mode_q && !rs |=> io_halt_o)
    else $error("halt missed");
  chk_halt_ignored: assert property (!io_halt_o && !(comm_err_i && mode_q) |=> !io_halt_o)
    else $error("halt without cause");
  chk_halt_sticky: assert property (io_halt_o && !rs |=> io_halt_o)
    else $error("halt dropped");
  chk_error_rise: assert property ($rose(io_halt_o) |-> ##2 error_o)
    else $error("error late");
  chk_flag_summary: assert property (rd_i && addr_i == `RIE_OFS_FLAGS |=> rdata_o[15] == |rdata_o[10:8])
    else $error("summary mismatch");
  chk_capture_word: assert property (rd_i && addr_i == `RIE_OFS_CAPTURE |=> rdata_o == $past(cap_q))
    else $error("capture wrong");
  chk_stop_bit: assert property (rd_i && addr_i == `RIE_OFS_FLAGS |=> rdata_o[10] == $past(io_halt_o))
    else $error("stop bit wrong");
  chk_rdata_idle: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("rdata not idle");
  chk_irq_masked: assert property (wr_i && addr_i == `RIE_OFS_IRQ_MASK && wdata_i[2:0] == 3'h0 |-> ##2 !irq_o)
    else $error("irq while masked");
  cover property (io_halt_o);
  cover property (irq_o);
  cover property (error_o && !io_halt_o);
endmodule
`default_nettype wire

// file: bench/remote_io_error_status_bench.sv
`timescale 1ns/1ps
`default_nettype none
module remote_io_error_status_bench
  import rie_pkg::*;
;
  logic clk_i = 0, rst_i = 1, wr_i = 0, rd_i = 0, restart_i = 0;
  logic [7:0] addr_i = 0;
  rie_word_t wdata_i = 0, rdata_o, miss_out, miss_in;
  logic io_halt_o, error_o, irq_o, err, jn;
  rie_node_t err_node, jn_node;
  rie_slave_e err_type, jn_type;
  int n_mismatch = 0, compares = 0, cyc = 0;
  always #5 clk_i = ~clk_i;
  rie_top i_rie_top (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .restart_i,
    .comm_err_i(err), .comm_err_node_i(err_node), .comm_err_type_i(err_type),
    .miss_out_i(miss_out), .miss_in_i(miss_in), .unreg_join_i(jn), .unreg_node_i(jn_node),
    .unreg_type_i(jn_type), .io_halt_o, .error_o, .irq_o);
  rie_net_model i_rie_net_model (.clk_i, .err_o(err), .err_node_o(err_node), .err_type_o(err_type),
    .join_o(jn), .join_node_o(jn_node), .join_type_o(jn_type), .miss_out_o(miss_out),
    .miss_in_o(miss_in));
  task summarize;
    if (n_mismatch == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input rie_word_t g, input rie_word_t e);
    compares++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input rie_word_t d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input rie_word_t e);
    @(posedge clk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, e);
  endtask
  // Irq level one edge after a status or mask change
  task irq_is(input logic e);
    @(posedge clk_i);
    #1 chk({15'h0, irq_o}, {15'h0, e});
  endtask
  // Missing flag follows the monitor; irq gated by mask
  task t_missing;
    wr(8'h0C, 16'h0000);
    i_rie_net_model.miss(16'h0020, 16'h0000);
    rd(8'h04, 16'h8100);
    rd(8'h06, 16'h0020);
    irq_is(1'b0);
    wr(8'h0C, 16'h0007);
    irq_is(1'b1);
    wr(8'h0B, 16'h0001);
    irq_is(1'b0);
    i_rie_net_model.miss(16'h0000, 16'h0000);
    rd(8'h04, 16'h0000);
  endtask
  // Error without stop mode changes nothing
  task t_ignore;
    i_rie_net_model.fail(4'h5, RIE_SLAVE_INPUT);
    rd(8'h04, 16'h0000);
    rd(8'h05, 16'h0000);
  endtask
  // Stop, later error not recaptured, then restart
  task t_stop(input rie_node_t n, input rie_slave_e t, input rie_word_t cap, input logic by_ctrl);
    i_rie_net_model.fail(n, t);
    rd(8'h04, 16'h8400);
    chk({14'h0, io_halt_o, error_o}, 16'h0003);
    rd(8'h05, cap);
    i_rie_net_model.fail(~n, rie_slave_e'(~t));
    rd(8'h05, cap);
    rd(8'h04, 16'h8400);
    if (by_ctrl) begin
      wr(8'h0A, 16'h0003);
    end else begin
      @(posedge clk_i);
      restart_i <= 1'b1;
      @(posedge clk_i);
      restart_i <= 1'b0;
    end
    rd(8'h04, 16'h0000);
    chk({15'h0, io_halt_o}, 16'h0000);
    rd(8'h05, 16'h0000);
  endtask
  // Unregistered join is sticky and marked per node
  task t_unreg;
    i_rie_net_model.join_unreg(4'h2, RIE_SLAVE_INPUT);
    rd(8'h04, 16'h8200);
    rd(8'h09, 16'h0004);
    rd(8'h08, 16'h0000);
    rd(8'h04, 16'h8200);
    wr(8'h0A, 16'h0003);
    rd(8'h09, 16'h0000);
  endtask
  // Cut a hang short
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h20, 16'h0000);
    rd(8'h0A, 16'h0000);
    t_missing();
    t_ignore();
    wr(8'h0A, 16'h0001);
    t_stop(4'hF, RIE_SLAVE_INPUT, 16'h800F, 1'b0);
    t_stop(4'h1, RIE_SLAVE_OUTPUT, 16'h0001, 1'b1);
    t_unreg();
    summarize();
  end
endmodule
bind rie_top rie_top_properties i_rie_top_properties (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i,
  .rd_i, .rdata_o, .restart_i, .comm_err_i, .comm_err_node_i, .comm_err_type_i, .io_halt_o,
  .error_o, .irq_o);
`default_nettype wire
